/* bench/period_match_timer8_test.sv */
// self-checking bench for the eight-bit period match timer
// assumes pmt8_pkg is compiled first; the bench is the only axi4-lite master
`default_nettype none
module period_match_timer8_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        ce       = 1'b1;
    logic        awvalid  = 1'b0;
    logic        awready;
    logic [7:0]  awaddr   = 8'h00;
    logic        wvalid   = 1'b0;
    logic        wready;
    logic [31:0] wdata    = 32'h0;
    logic [3:0]  wstrb    = 4'h0;
    logic        bvalid;
    logic        bready   = 1'b0;
    logic [1:0]  bresp;
    logic        arvalid  = 1'b0;
    logic        arready;
    logic [7:0]  araddr   = 8'h00;
    logic        rvalid;
    logic        rready   = 1'b0;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq_req;
    int          n_fail     = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    period_match_timer8 DUT (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .irq_req(irq_req)
    );

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // the longest scenario needs a few thousand cycles; this ceiling leaves ample margin
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t timeout", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        @(posedge core_clk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge core_clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, 4'hf, r);
        check(r, pmt8_pkg::RESP_OKAY, "write response");
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d, exp, what);
    endtask : rd_check

    task automatic test_reset_values();
        rd_check(pmt8_pkg::CTRL_OFS, 32'h00, "control reset");
        rd_check(pmt8_pkg::COUNT_OFS, 32'h00, "count reset");
        rd_check(pmt8_pkg::PERIOD_OFS, 32'hff, "period reset");
        rd_check(pmt8_pkg::IRQ_OFS, 32'h00, "irq reset");
        $display("test reset values done");
    endtask : test_reset_values

    task automatic test_registers();
        logic [31:0] d;
        logic [1:0]  r;
        wr(pmt8_pkg::COUNT_OFS, 32'h5a);
        rd_check(pmt8_pkg::COUNT_OFS, 32'h5a, "count rw");
        wr(pmt8_pkg::PERIOD_OFS, 32'ha5);
        rd_check(pmt8_pkg::PERIOD_OFS, 32'ha5, "period rw");
        wr(pmt8_pkg::CTRL_OFS, 32'hfb);
        rd_check(pmt8_pkg::CTRL_OFS, 32'h7b, "control bit 7");
        repeat (100) @(posedge core_clk);
        // timer is off, so the value must survive both the wait and the control write
        rd_check(pmt8_pkg::COUNT_OFS, 32'h5a, "count held");
        axi_write(pmt8_pkg::COUNT_OFS, 32'h11, 4'h0, r);
        check(r, pmt8_pkg::RESP_OKAY, "no-strobe response");
        rd_check(pmt8_pkg::COUNT_OFS, 32'h5a, "no-strobe write");
        axi_write(8'h10, 32'h1, 4'hf, r);
        check(r, pmt8_pkg::RESP_SLVERR, "unmapped write");
        axi_read(8'h10, d, r);
        check(r, pmt8_pkg::RESP_SLVERR, "unmapped read");
        check(d, 32'h0, "unmapped data");
        $display("test registers done");
    endtask : test_registers

    task automatic test_irq_mask();
        logic [3:0] vals[7] = '{4'h1, 4'h3, 4'h7, 4'hb, 4'hd, 4'he, 4'hf};
        foreach (vals[i]) begin
            wr(pmt8_pkg::IRQ_OFS, {28'h0, vals[i]});
            repeat (2) @(posedge core_clk);
            check(irq_req, vals[i] == 4'hf, "irq request");
            rd_check(pmt8_pkg::IRQ_OFS, {28'h0, vals[i]}, "irq readback");
        end
        wr(pmt8_pkg::IRQ_OFS, 32'h0);
        $display("test irq mask done");
    endtask : test_irq_mask

    task automatic wait_rise(output int t);
        do @(posedge core_clk); while (irq_req !== 1'b0);
        do @(posedge core_clk); while (irq_req !== 1'b1);
        t = cyc;
    endtask : wait_rise

    task automatic test_timing();
        logic [1:0] pre[5]  = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        logic [3:0] post[5] = '{4'h0, 4'h2, 4'h1, 4'h1, 4'hf};
        int t0, t1, ratio;
        wr(pmt8_pkg::PERIOD_OFS, 32'h03);
        foreach (pre[i]) begin
            ratio = pre[i][1] ? 16 : (pre[i][0] ? 4 : 1);
            wr(pmt8_pkg::IRQ_OFS, 32'h0e);
            wr(pmt8_pkg::CTRL_OFS, {25'h0, post[i], 1'b1, pre[i]});
            // the first interval starts at a free-running instruction phase, so skip it
            wait_rise(t0);
            wr(pmt8_pkg::IRQ_OFS, 32'h0e);
            wait_rise(t1);
            check(t1 - t0, 4 * ratio * 4 * (post[i] + 1), "flag interval");
        end
        wr(pmt8_pkg::CTRL_OFS, 32'h0);
        wr(pmt8_pkg::IRQ_OFS, 32'h0);
        $display("test timing done");
    endtask : test_timing

    task automatic test_scaler_clear();
        wr(pmt8_pkg::PERIOD_OFS, 32'h00);
        wr(pmt8_pkg::CTRL_OFS, 32'h7c);
        // a flag needs 64 cycles of matches; writes come far more often
        for (int i = 0; i < 12; i++) begin
            repeat (30) @(posedge core_clk);
            if (i % 2 == 0) wr(pmt8_pkg::COUNT_OFS, 32'h0);
            else wr(pmt8_pkg::CTRL_OFS, 32'h7c);
        end
        rd_check(pmt8_pkg::IRQ_OFS, 32'h0, "flag after clears");
        repeat (80) @(posedge core_clk);
        rd_check(pmt8_pkg::IRQ_OFS, 32'h1, "flag when left");
        wr(pmt8_pkg::CTRL_OFS, 32'h0);
        $display("test scaler clear done");
    endtask : test_scaler_clear

    task automatic test_mid_reset();
        wr(pmt8_pkg::PERIOD_OFS, 32'h42);
        wr(pmt8_pkg::COUNT_OFS, 32'h24);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        test_reset_values();
    endtask : test_mid_reset

    task automatic test_freeze();
        wr(pmt8_pkg::PERIOD_OFS, 32'hff);
        wr(pmt8_pkg::CTRL_OFS, 32'h06);
        wr(pmt8_pkg::COUNT_OFS, 32'h00);
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (1000) @(posedge core_clk);
        ce <= 1'b1;
        // only a few enabled cycles pass, far fewer than one 64-cycle count step
        rd_check(pmt8_pkg::COUNT_OFS, 32'h00, "count frozen by ce");
        wr(pmt8_pkg::CTRL_OFS, 32'h0);
        $display("test freeze done");
    endtask : test_freeze

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        test_reset_values();
        test_registers();
        test_irq_mask();
        test_timing();
        test_scaler_clear();
        test_mid_reset();
        test_freeze();
        test_done();
    end
endmodule : period_match_timer8_test
`default_nettype wire

/* include/pmt8_pkg.sv */
// shared constants and carrier types of the eight-bit period match timer
// assumes a 32-bit axi4-lite slave with byte addresses in the low 8 bits
`default_nettype none
package pmt8_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] COUNT_OFS  = 8'h04;
    localparam logic [7:0] PERIOD_OFS = 8'h08;
    localparam logic [7:0] IRQ_OFS    = 8'h0c;

    // reset values
    localparam logic [6:0] CTRL_RST   = 7'h00;
    localparam logic [7:0] COUNT_RST  = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [3:0] IRQ_RST    = 4'h0;

    // core_clk is the oscillator; one instruction cycle spans four of it
    localparam logic [1:0] INSTR_LAST = 2'h3;

    // prescaler terminal counts for 1:1, 1:4 and 1:16
    localparam logic [3:0] PRE_LIM_1  = 4'h0;
    localparam logic [3:0] PRE_LIM_4  = 4'h3;
    localparam logic [3:0] PRE_LIM_16 = 4'hf;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control register, bits 6..0 (bit 7 reads zero)
    typedef struct packed {
        logic [3:0] postscale_select;
        logic       timer_on;
        logic [1:0] prescale_select;
    } ctrl_type;

    // interrupt register, bits 3..0
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic match_irq_enable;
        logic match_irq_flag;
    } irq_type;
endpackage : pmt8_pkg
`default_nettype wire

/* rtl/period_match_timer8.sv */
// eight-bit period match timer with prescaler, postscaler and axi4-lite registers
// assumes the bus master is on core_clk; ce low freezes the timer and the bus
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none

// Functional notes
// RULE_01: count from instruction clock through prescaler
// RULE_02: prescale 00=1, 01=4, 1x=16
// RULE_03: count to period, then back to zero
// RULE_04: each match steps the postscaler
// RULE_05: postscale ratio is field value plus one
// RULE_06: postscaler output sets sticky match flag
// RULE_07: reset gives count zero, period all ones
// RULE_08: timer_on bit gates counting
// RULE_09: count or control write clears both scalers
// RULE_10: control write keeps count value
// RULE_11: count and period fully readable and writable
// RULE_12: control bit 7 ignores writes, reads zero
// RULE_13: request when flag and all enables set
module period_match_timer8 (
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // axi4-lite write address and data
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // axi4-lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // interrupt request
    output logic             irq_req
);
    logic                 awready_r;
    logic                 wready_r;
    logic                 bvalid_r;
    logic [1:0]           bresp_r;
    logic                 arready_r;
    logic                 rvalid_r;
    logic [31:0]          rdata_r;
    logic [1:0]           rresp_r;
    logic                 irq_req_r;
    logic [7:0]           waddr_r;
    logic [7:0]           wdat_r;
    logic                 wlane_r;
    logic [1:0]           qcnt_r;
    logic [7:0]           count_r;
    logic [7:0]           count_nxt;
    logic [7:0]           period_r;
    pmt8_pkg::ctrl_type   ctrl_r;
    pmt8_pkg::irq_type    irq_r;
    pmt8_pkg::irq_type    irq_nxt;

    // write decode: address and data may arrive in either order
    wire       do_write  = ~awready_r & ~wready_r & ~bvalid_r;
    wire       wr_en     = do_write & wlane_r;
    wire       wr_ctrl   = wr_en & (waddr_r == pmt8_pkg::CTRL_OFS);
    wire       wr_count  = wr_en & (waddr_r == pmt8_pkg::COUNT_OFS);
    wire       wr_period = wr_en & (waddr_r == pmt8_pkg::PERIOD_OFS);
    wire       wr_irq    = wr_en & (waddr_r == pmt8_pkg::IRQ_OFS);
    wire       wr_hit    = (waddr_r == pmt8_pkg::CTRL_OFS)
                         | (waddr_r == pmt8_pkg::COUNT_OFS)
                         | (waddr_r == pmt8_pkg::PERIOD_OFS)
                         | (waddr_r == pmt8_pkg::IRQ_OFS);
    wire       aw_take   = awvalid & awready_r;
    wire       w_take    = wvalid & wready_r;
    wire       ar_take   = arvalid & arready_r;

    // read decode
    wire       rd_ctrl   = araddr == pmt8_pkg::CTRL_OFS;
    wire       rd_count  = araddr == pmt8_pkg::COUNT_OFS;
    wire       rd_period = araddr == pmt8_pkg::PERIOD_OFS;
    wire       rd_irq    = araddr == pmt8_pkg::IRQ_OFS;
    wire       rd_hit    = rd_ctrl | rd_count | rd_period | rd_irq;
    wire [7:0] rd_byte   = rd_ctrl   ? {1'b0, ctrl_r} :                          // RULE_12
                           rd_count  ? count_r :                                 // RULE_11
                           rd_period ? period_r :
                           rd_irq    ? {4'h0, irq_r} : 8'h00;

    // timer datapath
    wire       scaler_clr = wr_ctrl | wr_count;                                  // RULE_09
    wire       instr_tick = ce & (qcnt_r == pmt8_pkg::INSTR_LAST);               // RULE_01
    wire       pre_step   = instr_tick & ctrl_r.timer_on;                        // RULE_08
    wire [3:0] pre_limit  = ctrl_r.prescale_select[1] ? pmt8_pkg::PRE_LIM_16 :   // RULE_02
                            ctrl_r.prescale_select[0] ? pmt8_pkg::PRE_LIM_4 :
                                                        pmt8_pkg::PRE_LIM_1;
    wire       pre_tick;
    wire [3:0] pre_cnt;
    wire       match      = count_r == period_r;                                 // RULE_03
    wire       match_step = pre_tick & match;                                    // RULE_04
    wire       post_tick;
    wire [3:0] post_cnt;

    step_divider u_prescaler (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .clr      (scaler_clr),
        .step     (pre_step),
        .limit    (pre_limit),
        .tick     (pre_tick),
        .cnt      (pre_cnt)
    );

    // terminal count equals the field, so the ratio is field plus one
    step_divider u_postscaler (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .clr      (scaler_clr),
        .step     (match_step),
        .limit    (ctrl_r.postscale_select),                                     // RULE_05
        .tick     (post_tick),
        .cnt      (post_cnt)
    );

    // a software write beats a same-cycle increment; a control write leaves count alone
    assign count_nxt = wr_count ? wdat_r :                                       // RULE_11
                       pre_tick ? (match ? 8'h00 : count_r + 8'h01) :            // RULE_03
                       count_r;                                                  // RULE_10

    // hardware set wins over a software clear in the same cycle
    always_comb begin
        irq_nxt = irq_r;
        if (wr_irq) begin
            irq_nxt = pmt8_pkg::irq_type'(wdat_r[3:0]);
        end
        if (post_tick) begin
            irq_nxt.match_irq_flag = 1'b1;                                       // RULE_06
        end
    end

    wire irq_cond = irq_r.match_irq_flag & irq_r.match_irq_enable
                  & irq_r.peripheral_irq_enable & irq_r.global_irq_enable;       // RULE_13

    // instruction phase counter; it free-runs so that writes do not shift phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            qcnt_r <= 2'h0;
        end else if (ce) begin
            qcnt_r <= qcnt_r + 2'h1;
        end
    end

    // timer registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_r   <= pmt8_pkg::COUNT_RST;                                    // RULE_07
            period_r  <= pmt8_pkg::PERIOD_RST;                                   // RULE_07
            ctrl_r    <= pmt8_pkg::CTRL_RST;
            irq_r     <= pmt8_pkg::IRQ_RST;
            irq_req_r <= 1'b0;
        end else if (ce) begin
            count_r   <= count_nxt;
            irq_r     <= irq_nxt;
            irq_req_r <= irq_cond;
            if (wr_period) begin
                period_r <= wdat_r;                                              // RULE_11
            end
            if (wr_ctrl) begin
                ctrl_r <= wdat_r[6:0];                                           // RULE_12
            end
        end
    end

    // write channels: each ready drops once its beat is held
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= pmt8_pkg::RESP_OKAY;
            waddr_r   <= 8'h00;
            wdat_r    <= 8'h00;
            wlane_r   <= 1'b0;
        end else if (ce) begin
            if (aw_take) begin
                awready_r <= 1'b0;
                waddr_r   <= awaddr;
            end
            if (w_take) begin
                wready_r <= 1'b0;
                wdat_r   <= wdata[7:0];
                wlane_r  <= wstrb[0];
            end
            if (do_write) begin
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? pmt8_pkg::RESP_OKAY : pmt8_pkg::RESP_SLVERR;
            end else if (bvalid_r & bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel: one outstanding read, data captured at the address edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= pmt8_pkg::RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= {24'h00_0000, rd_byte};
                rresp_r   <= rd_hit ? pmt8_pkg::RESP_OKAY : pmt8_pkg::RESP_SLVERR;
            end else if (rvalid_r & rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign irq_req = irq_req_r;

    // enabled cycles since the last prescaler output, for the spacing check;
    // the first output after a scaler clear starts at a free-running phase, so it is skipped
    logic [5:0] pre_gap_r;
    logic       pre_seen_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_gap_r  <= 6'h00;
            pre_seen_r <= 1'b0;
        end else if (ce) begin
            pre_gap_r  <= (pre_tick | scaler_clr) ? 6'h00 : pre_gap_r + 6'h01;
            pre_seen_r <= pre_tick | (pre_seen_r & ~scaler_clr);
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_wrap_on_match: assert property ( // RULE_03
        pre_tick & match & ~wr_count |=> count_r == 8'h00)
        else $error("count did not wrap to zero after match");

    a_count_step: assert property ( // RULE_03
        pre_tick & ~match & ~wr_count |=> count_r == $past(count_r) + 8'h01)
        else $error("count did not advance by one");

    a_halt_when_off: assert property ( // RULE_08
        ~ctrl_r.timer_on & ~wr_count |=> count_r == $past(count_r))
        else $error("count moved while timer is off");

    a_pre_ratio: assert property ( // RULE_02
        pre_tick |-> pre_cnt == pre_limit && ctrl_r.timer_on)
        else $error("prescaler fired off its terminal count");

    a_post_ratio: assert property ( // RULE_05
        post_tick |-> post_cnt == ctrl_r.postscale_select && pre_tick && match)
        else $error("postscaler fired off its terminal count");

    a_flag_set: assert property ( // RULE_06
        post_tick |=> irq_r.match_irq_flag ##1 irq_req_r == $past(irq_cond))
        else $error("postscaler output did not set the match flag");

    a_flag_sticky: assert property ( // RULE_06
        ce & irq_r.match_irq_flag & ~wr_irq |=> irq_r.match_irq_flag)
        else $error("match flag dropped without a software write");

    a_scaler_clear: assert property ( // RULE_09
        ce & scaler_clr |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
        else $error("scalers not cleared by register write");

    a_ctrl_keeps_count: assert property ( // RULE_10
        ce & wr_ctrl |=> count_r == $past(count_r))
        else $error("control write changed the count");

    a_msb_reads_zero: assert property ( // RULE_12
        ce & ar_take & rd_ctrl |=> rvalid_r && rdata_r[7] == 1'b0)
        else $error("control bit 7 read back as one");

    a_irq_gate: assert property ( // RULE_13
        ce |=> irq_req_r == $past(irq_cond))
        else $error("interrupt request does not follow flag and enables");

    a_pre_spacing: assert property ( // RULE_01
        pre_tick & pre_seen_r |-> pre_gap_r == (ctrl_r.prescale_select[1] ?
            {pmt8_pkg::PRE_LIM_16, pmt8_pkg::INSTR_LAST} : ctrl_r.prescale_select[0] ?
            {pmt8_pkg::PRE_LIM_4, pmt8_pkg::INSTR_LAST} :
            {pmt8_pkg::PRE_LIM_1, pmt8_pkg::INSTR_LAST}))
        else $error("prescaler output spacing does not match the selected ratio");

    a_post_step: assert property ( // RULE_04
        match_step & ~post_tick |=> post_cnt == $past(post_cnt) + 4'h1)
        else $error("match did not advance the postscaler");

    a_count_write: assert property ( // RULE_11
        ce & wr_count |=> count_r == $past(wdat_r))
        else $error("count write did not land");

    a_period_write: assert property ( // RULE_11
        ce & wr_period |=> period_r == $past(wdat_r))
        else $error("period write did not land");

    a_ctrl_write: assert property ( // RULE_12
        ce & wr_ctrl |=> ctrl_r == $past(wdat_r[6:0]))
        else $error("control write did not land in bits 6 to 0");

    a_ce_freeze: assert property (
        ~ce |=> $stable(count_r) && $stable(period_r) && $stable(ctrl_r)
                && $stable(irq_r) && $stable(qcnt_r))
        else $error("state moved while clock enable was low");

    a_write_answer: assert property (
        ce & do_write |=> bvalid_r)
        else $error("performed write gave no response");

    a_bresp_hold: assert property (
        ce & bvalid_r & ~bready |=> bvalid_r && bresp_r == $past(bresp_r))
        else $error("write response dropped before it was taken");

    a_rdata_hold: assert property (
        ce & rvalid_r & ~rready |=> rvalid_r && rdata_r == $past(rdata_r))
        else $error("read data dropped before it was taken");

    c_wrap: cover property (pre_tick & match);
    c_flag: cover property (post_tick & wr_irq);
    c_write_read: cover property (do_write ##[1:20] ar_take);
    c_freeze: cover property (~ce ##1 ce);
    c_pre16: cover property (pre_tick & pre_seen_r & ctrl_r.prescale_select[1]);
endmodule : period_match_timer8
`default_nettype wire

/* rtl/step_divider.sv */
// programmable step divider used as prescaler and postscaler
// assumes clr, step and limit come from logic on the same clock
`default_nettype none
module step_divider (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // control
    input  wire logic       clr,
    input  wire logic       step,
    input  wire logic [3:0] limit,
    // result
    output logic            tick,
    output logic [3:0]      cnt
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // a tick is the step that reaches the terminal count
    assign tick    = step & ~clr & (cnt_r == limit);
    assign cnt_nxt = clr  ? 4'h0 :
                     tick ? 4'h0 :
                     step ? cnt_r + 4'h1 : cnt_r;
    assign cnt     = cnt_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : step_divider
`default_nettype wire
